// >>> src/tpio_pkg.sv
/*
 * tpio_pkg: constants and carrier types for the three-port parallel I/O.
 * assumes an 8-bit host I/O bus with a 10-bit port address.
 */
package tpio_pkg;

  // host bus shape and fixed window
  localparam int          ADDR_W    = 10;
  localparam logic [9:0]  BASE_ADDR = 10'h300;
  localparam logic [1:0]  OFS_A     = 2'h0;
  localparam logic [1:0]  OFS_B     = 2'h1;
  localparam logic [1:0]  OFS_C     = 2'h2;
  localparam logic [1:0]  OFS_CFG   = 2'h3;

  // configuration word fields
  localparam int CFG_CLO_DIR = 0;
  localparam int CFG_B_DIR   = 1;
  localparam int CFG_B_MODE  = 2;
  localparam int CFG_CHI_DIR = 3;
  localparam int CFG_A_DIR   = 4;
  localparam int CFG_A_MODE0 = 5;
  localparam int CFG_A_MODE1 = 6;
  localparam int CFG_LOAD    = 7;

  // all inputs, basic mode
  localparam logic [7:0] CFG_RESET   = 8'h9B;
  localparam logic [7:0] LATCH_RESET = 8'h00;

  // split-port lines taken over in the handshake modes
  localparam int PC_B_INTR = 0;
  localparam int PC_B_FLAG = 1;
  localparam int PC_B_STRB = 2;
  localparam int PC_A_INTR = 3;
  localparam int PC_A_STB  = 4;
  localparam int PC_A_IBF  = 5;
  localparam int PC_A_ACK  = 6;
  localparam int PC_A_OBF  = 7;

  // one decoded host access
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [3:0] sel;   // one-hot: A, B, C, cfg
  } tpio_access_type;

  // handshake state of one byte port
  typedef struct packed {
    logic [7:0] inData;
    logic       ibf;
    logic       obfN;
    logic       intr;
  } tpio_hs_type;

endpackage : tpio_pkg

// >>> src/tpio_decode.sv
/*
 * tpio_decode: turns host strobes and address into a one-cycle access.
 * assumes strobes are one-cycle pulses synchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module tpio_decode
  import tpio_pkg::*;
(
  // host bus
  input  wire logic [ADDR_W-1:0] hostAddr,
  input  wire logic              hostRd,
  input  wire logic              hostWr,
  // decoded access
  output tpio_access_type        access
);

  logic hit;

  // fixed window: the upper address bits must match the base exactly
  assign hit = (hostAddr[ADDR_W-1:2] == BASE_ADDR[ADDR_W-1:2]);

  // offsets 0..3 pick one of the four registers
  always_comb begin
    access.rd  = hostRd & hit;
    access.wr  = hostWr & hit;
    access.sel = 4'h0;
    if (hit) begin
      access.sel[hostAddr[1:0]] = 1'b1;
    end
  end

endmodule // tpio_decode
`default_nettype wire

// >>> src/tpio_handshake.sv
/*
 * tpio_handshake: strobe/acknowledge handshake for one byte port.
 * assumes strobe and acknowledge lines are synchronous, active low.
 */
`timescale 1ns/1ps
`default_nettype none
module tpio_handshake
  import tpio_pkg::*;
(
  // clock and reset
  input  wire logic  core_clk,
  input  wire logic  resetn,
  // mode
  input  wire logic  active,
  input  wire logic  inDir,
  input  wire logic  bidir,
  // lines
  input  wire logic  stbN,
  input  wire logic  ackN,
  input  wire logic [7:0] pinIn,
  // host side
  input  wire logic  hostRd,
  input  wire logic  hostWr,
  output tpio_hs_type hs
);

  tpio_hs_type hs_q, hs_d;
  logic stbPrev_q, stbPrev_d;
  logic ackPrev_q, ackPrev_d;
  logic doIn, doOut;

  assign doIn  = active & (inDir | bidir);
  assign doOut = active & (~inDir | bidir);
  assign hs    = hs_q;

  // clears are applied first so that a same-cycle line event wins
  always_comb begin
    hs_d      = hs_q;
    stbPrev_d = stbN;
    ackPrev_d = ackN;
    if (!active) begin
      hs_d.ibf  = 1'b0;
      hs_d.obfN = 1'b1;
      hs_d.intr = 1'b0;
    end
    // host clears come before every line event below, so events win
    if (doIn && hostRd) begin
      hs_d.ibf  = 1'b0;
      hs_d.intr = 1'b0;
    end
    if (doOut && hostWr) begin
      hs_d.obfN = 1'b0;
      hs_d.intr = 1'b0;
    end
    if (doIn) begin
      if (stbPrev_q && !stbN) begin
        hs_d.inData = pinIn;
        hs_d.ibf    = 1'b1;
      end
      if (!stbPrev_q && stbN && hs_q.ibf) begin
        hs_d.intr = 1'b1;
      end
    end
    if (doOut) begin
      if (ackPrev_q && !ackN) begin
        hs_d.obfN = 1'b1;
      end
      if (!ackPrev_q && ackN && !hs_q.obfN) begin
        hs_d.intr = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hs_q      <= '{8'h00, 1'b0, 1'b1, 1'b0};
      stbPrev_q <= 1'b1;
      ackPrev_q <= 1'b1;
    end else begin
      hs_q      <= hs_d;
      stbPrev_q <= stbPrev_d;
      ackPrev_q <= ackPrev_d;
    end
  end

endmodule // tpio_handshake
`default_nettype wire

// >>> src/tpio_top.sv
/*
 * tpio_top: three 8-bit ports and a configuration word behind a fixed
 * four-address window on an 8-bit host I/O bus.
 * assumes host strobes and port pins are synchronous to core_clk and
 * that the board resolves each pin from its output enable.
 */
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
// Overview of operation
// - three 8-bit ports, directions set by the configuration word
// - first and second ports switch as bytes; split port as two nibbles
// - offsets 0,1,2,3 select first, second, split port and config word
// - window base fixed at 0x300, not relocatable
// - config bits 0,1,3,4 direct lower C, B, upper C, A; 1 = input
// - bit 2 second-group mode; bits 6:5 first-group mode 00/01/1X
// - mode and direction fields applied only when bit 7 written as 1
// - basic mode moves data directly with no handshake
// - strobed mode hands data via strobes; split port carries handshake
// - bidirectional mode: first port both ways, five split lines control
// - reading a port returns the current byte on its lines; strobed inputs return the strobe-captured byte
// - writing a port latches the byte and drives output lines
module tpio_top
  import tpio_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              resetn,
  // host i/o bus
  input  wire logic [ADDR_W-1:0] hostAddr,
  input  wire logic [7:0]        hostWrData,
  input  wire logic              hostRd,
  input  wire logic              hostWr,
  output var  logic [7:0]        hostRdData,
  output var  logic              hostRdValid,
  // first byte port
  input  wire logic [7:0]        portAIn,
  output var  logic [7:0]        portAOut,
  output var  logic [7:0]        portAOe,
  // second byte port
  input  wire logic [7:0]        portBIn,
  output var  logic [7:0]        portBOut,
  output var  logic [7:0]        portBOe,
  // split nibble port
  input  wire logic [7:0]        portCIn,
  output var  logic [7:0]        portCOut,
  output var  logic [7:0]        portCOe
);

  ////////////////////////////////////////////////////////////////////
  // host access decode

  tpio_access_type acc;

  // decode is purely combinational; the one-cycle strobes it passes on
  // are acted on at the same edge that samples them
  tpio_decode u_decode (
    .hostAddr (hostAddr),
    .hostRd   (hostRd),
    .hostWr   (hostWr),
    .access   (acc)
  );

  ////////////////////////////////////////////////////////////////////
  // configuration and mode fields

  // the stored word reads back whole, load bit included
  logic [7:0] cfg_q, cfg_d;
  logic       aInDir, bInDir, cLoIn, cHiIn;
  logic       aStrobed, aBidir, bStrobed;

  // decoded view of the stored word
  // mode 1X of the first group is bidirectional whatever bit 5 holds
  assign cLoIn    = cfg_q[CFG_CLO_DIR];
  assign bInDir   = cfg_q[CFG_B_DIR];
  assign cHiIn    = cfg_q[CFG_CHI_DIR];
  assign aInDir   = cfg_q[CFG_A_DIR];
  assign bStrobed = cfg_q[CFG_B_MODE];
  assign aBidir   = cfg_q[CFG_A_MODE1];
  assign aStrobed = ~cfg_q[CFG_A_MODE1] & cfg_q[CFG_A_MODE0];

  ////////////////////////////////////////////////////////////////////
  // handshake engines, one per byte-port group

  // in basic mode the engines sit idle with their flags at rest
  tpio_hs_type hsA, hsB;
  logic        aRd, aWr, bRd, bWr;

  assign aRd = acc.rd & acc.sel[OFS_A];
  assign aWr = acc.wr & acc.sel[OFS_A];
  assign bRd = acc.rd & acc.sel[OFS_B];
  assign bWr = acc.wr & acc.sel[OFS_B];

  // group A uses fixed upper split lines for strobe and acknowledge
  tpio_handshake u_hsA (
    .core_clk (core_clk),
    .resetn   (resetn),
    .active   (aStrobed | aBidir),
    .inDir    (aInDir),
    .bidir    (aBidir),
    .stbN     (portCIn[PC_A_STB]),
    .ackN     (portCIn[PC_A_ACK]),
    .pinIn    (portAIn),
    .hostRd   (aRd),
    .hostWr   (aWr),
    .hs       (hsA)
  );

  // group B shares one line as strobe or acknowledge by direction,
  // so a direction change mid-transfer may see a spurious edge on it
  tpio_handshake u_hsB (
    .core_clk (core_clk),
    .resetn   (resetn),
    .active   (bStrobed),
    .inDir    (bInDir),
    .bidir    (1'b0),
    .stbN     (portCIn[PC_B_STRB]),
    .ackN     (portCIn[PC_B_STRB]),
    .pinIn    (portBIn),
    .hostRd   (bRd),
    .hostWr   (bWr),
    .hs       (hsB)
  );

  ////////////////////////////////////////////////////////////////////
  // configuration word and output latches

  logic [7:0] latA_q, latA_d;
  logic [7:0] latB_q, latB_d;
  logic [7:0] latC_q, latC_d;

  // a load clears every latch so the latch-driven outputs start from zero
  // a config write with bit 7 clear is dropped whole, never half-applied
  always_comb begin
    cfg_d  = cfg_q;
    latA_d = latA_q;
    latB_d = latB_q;
    latC_d = latC_q;
    if (acc.wr) begin
      if (acc.sel[OFS_CFG] && hostWrData[CFG_LOAD]) begin
        cfg_d  = hostWrData;
        latA_d = LATCH_RESET;
        latB_d = LATCH_RESET;
        latC_d = LATCH_RESET;
      end
      if (acc.sel[OFS_A]) begin
        latA_d = hostWrData;
      end
      if (acc.sel[OFS_B]) begin
        latB_d = hostWrData;
      end
      if (acc.sel[OFS_C]) begin
        latC_d = hostWrData;
      end
    end
  end

  // reset lands in the all-input basic configuration,
  // so no line is driven until the host has chosen a direction
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q  <= CFG_RESET;
      latA_q <= LATCH_RESET;
      latB_q <= LATCH_RESET;
      latC_q <= LATCH_RESET;
    end else begin
      cfg_q  <= cfg_d;
      latA_q <= latA_d;
      latB_q <= latB_d;
      latC_q <= latC_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin drive

  logic [7:0] aOut_d, aOe_d, bOut_d, bOe_d, cOut_d, cOe_d;
  logic [7:0] aOut_q, aOe_q, bOut_q, bOe_q, cOut_q, cOe_q;
  logic [7:0] cDirOe;

  // basic split-port directions, one nibble each
  // the nibbles follow their own bits, so the port may face both ways
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_cdir
      if (gi < 4) begin : g_lo
        assign cDirOe[gi] = ~cLoIn;
      end else begin : g_hi
        assign cDirOe[gi] = ~cHiIn;
      end
    end
  endgenerate

  // byte ports switch as a whole; bidir A drives only while acked
  // the turnaround lags the acknowledge line by one cycle, which the far
  // side must allow for before it drives the port itself
  always_comb begin
    aOut_d = latA_q;
    bOut_d = latB_q;
    aOe_d  = {8{~aInDir}};
    bOe_d  = {8{~bInDir}};
    if (aBidir) begin
      aOe_d = {8{~portCIn[PC_A_ACK]}};
    end
    cOut_d = latC_q;
    cOe_d  = cDirOe;
    // second group takes bits 0..2
    if (bStrobed) begin
      cOut_d[PC_B_INTR] = hsB.intr;
      cOe_d[PC_B_INTR]  = 1'b1;
      cOut_d[PC_B_FLAG] = bInDir ? hsB.ibf : hsB.obfN;
      cOe_d[PC_B_FLAG]  = 1'b1;
      cOe_d[PC_B_STRB]  = 1'b0;
    end
    // first group takes bit 3 plus its strobe pair, its ack pair, or both pairs when bidirectional
    if (aStrobed || aBidir) begin
      cOut_d[PC_A_INTR] = hsA.intr;
      cOe_d[PC_A_INTR]  = 1'b1;
      if (aInDir || aBidir) begin
        cOe_d[PC_A_STB]  = 1'b0;
        cOut_d[PC_A_IBF] = hsA.ibf;
        cOe_d[PC_A_IBF]  = 1'b1;
      end
      if (!aInDir || aBidir) begin
        cOe_d[PC_A_ACK]  = 1'b0;
        cOut_d[PC_A_OBF] = hsA.obfN;
        cOe_d[PC_A_OBF]  = 1'b1;
      end
    end
  end

  // every pin output is a flop, so outputs lag the latch by one cycle
  // reset leaves every enable low so the board pull-ups own the lines
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      aOut_q <= LATCH_RESET;
      aOe_q  <= LATCH_RESET;
      bOut_q <= LATCH_RESET;
      bOe_q  <= LATCH_RESET;
      cOut_q <= LATCH_RESET;
      cOe_q  <= LATCH_RESET;
    end else begin
      aOut_q <= aOut_d;
      aOe_q  <= aOe_d;
      bOut_q <= bOut_d;
      bOe_q  <= bOe_d;
      cOut_q <= cOut_d;
      cOe_q  <= cOe_d;
    end
  end

  assign portAOut = aOut_q;
  assign portAOe  = aOe_q;
  assign portBOut = bOut_q;
  assign portBOe  = bOe_q;
  assign portCOut = cOut_q;
  assign portCOe  = cOe_q;

  ////////////////////////////////////////////////////////////////////
  // host read path

  logic [7:0] rdData_q, rdData_d;
  logic       rdValid_q, rdValid_d;
  logic [7:0] aLine, bLine, cLine;

  // what the line shows: own drive where enabled, the pin otherwise
  // a basic-mode read is the line as it stands, with no capture
  assign aLine = (aOe_q & aOut_q) | (~aOe_q & portAIn);
  assign bLine = (bOe_q & bOut_q) | (~bOe_q & portBIn);
  assign cLine = (cOe_q & cOut_q) | (~cOe_q & portCIn);

  // strobed inputs return the byte captured on the strobe; reading
  // the live pins there would race the far side's next byte
  always_comb begin
    rdValid_d = acc.rd;
    rdData_d  = rdData_q;
    if (acc.rd) begin
      unique case (1'b1)
        acc.sel[OFS_A]: rdData_d =
          ((aStrobed && aInDir) || aBidir) ? hsA.inData : aLine;
        acc.sel[OFS_B]: rdData_d =
          (bStrobed && bInDir) ? hsB.inData : bLine;
        acc.sel[OFS_C]: rdData_d = cLine;
        acc.sel[OFS_CFG]: rdData_d = cfg_q;
        default: rdData_d = 8'h00;
      endcase
    end
  end

  // answer one cycle after the read strobe
  // read data holds between reads; only the valid pulse marks a new byte
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdData_q  <= 8'h00;
      rdValid_q <= 1'b0;
    end else begin
      rdData_q  <= rdData_d;
      rdValid_q <= rdValid_d;
    end
  end

  assign hostRdData  = rdData_q;
  assign hostRdValid = rdValid_q;

endmodule // tpio_top
`default_nettype wire

// >>> verification/tpio_checker.sv
/* tpio_checker: port timing checks for tpio_top.
   assumes it is bound to tpio_top and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module tpio_checker
  import tpio_pkg::*;
(
  // clock and reset
  input wire logic              core_clk,
  input wire logic              resetn,
  // host bus
  input wire logic [ADDR_W-1:0] hostAddr,
  input wire logic [7:0]        hostWrData,
  input wire logic              hostRd,
  input wire logic              hostWr,
  input wire logic              hostRdValid,
  // port drive
  input wire logic [7:0]        portAOut,
  input wire logic [7:0]        portAOe,
  input wire logic [7:0]        portBOut,
  input wire logic [7:0]        portBOe,
  input wire logic [7:0]        portCOut,
  input wire logic [7:0]        portCOe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////
  // window decode, kept apart from the design's own decoder
  logic inWin;
  logic cfgWr;
  logic cfgLd;
  assign inWin = hostAddr[9:2] == 8'hC0;
  assign cfgWr = hostWr && inWin && hostAddr[1:0] == 2'h3;
  assign cfgLd = cfgWr && hostWrData[7];
  // a load that leaves the first group in basic mode
  logic ld00;
  assign ld00 = cfgLd && hostWrData[6:5] == 2'b00;
  AST_RD_ANSWER: assert property (hostRd && inWin |=> hostRdValid)
    else $error("window read not answered");
  AST_RD_IN_WINDOW: assert property (
    hostRdValid |-> $past(hostRd) && $past(inWin))
    else $error("answer without window read");
  AST_A_DIR: assert property (
    ld00 |-> ##2 portAOe == {8{~$past(hostWrData[4], 2)}})
    else $error("first port direction wrong");
  AST_B_DIR: assert property (
    cfgLd && !hostWrData[2] |-> ##2
    portBOe == {8{~$past(hostWrData[1], 2)}})
    else $error("second port direction wrong");
  AST_C_DIR: assert property (
    ld00 && !hostWrData[2] |-> ##2
    portCOe == {{4{~$past(hostWrData[3], 2)}},
                {4{~$past(hostWrData[0], 2)}}})
    else $error("split port direction wrong");
  // B and C enables follow only the stored word, so an unloaded write moves neither
  AST_NO_LOAD: assert property (
    cfgWr && !hostWrData[7] |-> ##2 $stable(portBOe) && $stable(portCOe))
    else $error("config applied without load bit");
  AST_LOAD_CLEARS: assert property (
    (ld00 && !hostWrData[2]) ##1 !hostWr |=> portAOut == 8'h00
    && portBOut == 8'h00 && portCOut == 8'h00)
    else $error("latches not cleared on load");
  AST_WRITE_A: assert property (
    (hostWr && inWin && hostAddr[1:0] == 2'h0) ##1 !hostWr
    |=> portAOut == $past(hostWrData, 2))
    else $error("first port latch wrong");
  AST_RESET_STATE: assert property ($rose(resetn) |->
    (portAOe | portBOe | portCOe | portAOut) == 8'h00)
    else $error("reset state wrong");
  // main scenarios
  cover property (cfgLd && hostWrData[6]);
  cover property (cfgLd && hostWrData[2]);
  cover property (hostRd && inWin);
endmodule // tpio_checker
bind tpio_top tpio_checker u_tpio_checker (
  .core_clk(core_clk), .resetn(resetn), .hostAddr(hostAddr),
  .hostWrData(hostWrData), .hostRd(hostRd), .hostWr(hostWr),
  .hostRdValid(hostRdValid), .portAOut(portAOut), .portAOe(portAOe),
  .portBOut(portBOut), .portBOe(portBOe), .portCOut(portCOut),
  .portCOe(portCOe));
`default_nettype wire

// >>> verification/tpio_ext_lines.sv
/* tpio_ext_lines: far-side lines with board pull-ups.
   assumes the device wins where both sides drive a line. */
`timescale 1ns/1ps
`default_nettype none
module tpio_ext_lines (
  // device side
  input  wire logic [7:0] portAOut,
  input  wire logic [7:0] portAOe,
  input  wire logic [7:0] portBOut,
  input  wire logic [7:0] portBOe,
  input  wire logic [7:0] portCOut,
  input  wire logic [7:0] portCOe,
  // far-side drive, strobes and acks ride on extC
  input  wire logic [7:0] extA,
  input  wire logic [7:0] extB,
  input  wire logic [7:0] extC,
  input  wire logic [2:0] extDrv,
  // resolved pins
  output var  logic [7:0] portAIn,
  output var  logic [7:0] portBIn,
  output var  logic [7:0] portCIn
);
  // undriven lines float to the pull-up, never to the last value
  function automatic logic [7:0] lvl(input logic [7:0] o, e, x,
                                     input logic d);
    lvl = (o & e) | (~e & (d ? x : 8'hFF));
  endfunction
  always_comb begin
    portAIn = lvl(portAOut, portAOe, extA, extDrv[0]);
    portBIn = lvl(portBOut, portBOe, extB, extDrv[1]);
    portCIn = lvl(portCOut, portCOe, extC, extDrv[2]);
  end
endmodule // tpio_ext_lines
`default_nettype wire

// >>> verification/tb.sv
/* tb: host-bus tests of tpio_top against the far-side line model.
   assumes a 100 ns core clock and pull-ups on every line. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tpio_pkg::*;
  logic       core_clk, resetn, hostRd, hostWr, hostRdValid;
  logic [9:0] hostAddr;
  logic [7:0] hostWrData, hostRdData, portAIn, portAOut, portAOe;
  logic [7:0] portBIn, portBOut, portBOe, portCIn, portCOut, portCOe;
  logic [7:0] extA, extB, extC, rdByte, w;
  logic [2:0] extDrv;
  int         n_fail, n_compared, i;
  tpio_top u_tpio_top (.core_clk(core_clk), .resetn(resetn),
    .hostAddr(hostAddr), .hostWrData(hostWrData), .hostRd(hostRd),
    .hostWr(hostWr), .hostRdData(hostRdData), .hostRdValid(hostRdValid),
    .portAIn(portAIn), .portAOut(portAOut), .portAOe(portAOe),
    .portBIn(portBIn), .portBOut(portBOut), .portBOe(portBOe),
    .portCIn(portCIn), .portCOut(portCOut), .portCOe(portCOe));
  tpio_ext_lines u_tpio_ext_lines (.portAOut(portAOut), .portAOe(portAOe),
    .portBOut(portBOut), .portBOe(portBOe), .portCOut(portCOut),
    .portCOe(portCOe), .extA(extA), .extB(extB), .extC(extC),
    .extDrv(extDrv), .portAIn(portAIn), .portBIn(portBIn),
    .portCIn(portCIn));
  always #50 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [7:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one idle edge after each strobe, so no signal is set twice per step
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge core_clk);
    hostAddr <= a;
    hostWrData <= d;
    hostWr <= 1'b1;
    @(posedge core_clk);
    hostWr <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    int k;
    @(posedge core_clk);
    hostAddr <= a;
    hostRd <= 1'b1;
    @(posedge core_clk);
    hostRd <= 1'b0;
    for (k = 0; k < 4 && hostRdValid !== 1'b1; k++) @(negedge core_clk);
    if (k == 4) begin
      n_fail++;
      wrap_up();
    end
    d = hostRdData;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {core_clk, resetn, hostRd, hostWr, hostAddr, hostWrData} = '0;
    {extA, extB, extC, extDrv} = '0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    extA <= 8'h5A;
    extB <= 8'hC3;
    extC <= 8'h96;
    extDrv <= 3'b111;
    @(negedge core_clk);
    check("resetOe", 8'h00, portAOe | portBOe | portCOe);
    rd(10'h303, rdByte);
    check("cfgReset", 8'h9B, rdByte);
    wr(10'h303, 8'h9B);
    rd(10'h300, rdByte);
    check("readA", 8'h5A, rdByte);
    rd(10'h301, rdByte);
    check("readB", 8'hC3, rdByte);
    rd(10'h302, rdByte);
    check("readC", 8'h96, rdByte);
    wr(10'h303, 8'h83);
    wr(10'h300, 8'h55);
    check("outA", 8'h55, portAOut);
    rd(10'h300, rdByte);
    check("readBackA", 8'h55, rdByte);
    wr(10'h302, 8'h3C);
    rd(10'h302, rdByte);
    check("splitC", 8'h36, rdByte);
    wr(10'h303, 8'h1B);
    check("noLoad", 8'hF0, portCOe);
    check("noLoadClr", 8'h55, portAOut);
    wr(10'h200, 8'hAA);
    check("aliasWr", 8'h55, portAOut);
    @(posedge core_clk);
    hostAddr <= 10'h304;
    hostRd <= 1'b1;
    @(posedge core_clk);
    hostRd <= 1'b0;
    @(negedge core_clk);
    check("outsideRd", 8'h00, {7'h0, hostRdValid});
    wr(10'h303, 8'h80);
    check("loadClr", 8'h00, portAOut);
    wr(10'h301, 8'hA5);
    check("outB", 8'hA5, portBOut);
    // direction table, bits 1,3 and bits 0,4 switched together in pairs
    for (i = 0; i < 4; i++) begin
      w = (i == 0) ? 8'h80 : (i == 1) ? 8'h8A : (i == 2) ? 8'h91 : 8'h9B;
      wr(10'h303, w);
      check("dirA", {8{~w[4]}}, portAOe);
      check("dirB", {8{~w[1]}}, portBOe);
      check("dirC", {{4{~w[3]}}, {4{~w[0]}}}, portCOe);
    end
    wr(10'h303, 8'h84);
    check("modeB1", 8'h03, {5'h0, portCOe[2:0]});
    wr(10'h303, 8'hA0);
    check("modeA1", 8'h05, {5'h0, portCOe[7:6], portCOe[3]});
    wr(10'h303, 8'hC0);
    check("modeA2", 8'h15, {3'h0, portCOe[7:3]});
    // strobed input: byte caught at strobe fall, later pin changes ignored
    extC <= 8'hFF;
    wr(10'h303, 8'h86);
    // let the released strobe line be seen high before pulling it low
    @(posedge core_clk);
    extB <= 8'hA5;
    @(posedge core_clk);
    extC <= 8'hFB;
    for (i = 0; i < 8 && portCOut[1] !== 1'b1; i++) @(negedge core_clk);
    if (i == 8) begin
      n_fail++;
      wrap_up();
    end
    @(posedge core_clk);
    extB <= 8'h11;
    extC <= 8'hFF;
    rd(10'h301, rdByte);
    check("strobedB", 8'hA5, rdByte);
    check("intrB", 8'h01, {7'h0, portCOut[0]});
    repeat (3) @(negedge core_clk);
    check("ibfClr", 8'h00, {6'h0, portCOut[1:0]});
    wrap_up();
  end
endmodule // tb
`default_nettype wire
